//--- crosspoint_pkg.sv
/*
  Shared constants of the crosspoint configuration logic: array size,
  programming word layout, and synchroniser depth.
  Assumes nothing of its surroundings; used by all design files.
*/
package crosspoint_pkg;
  localparam int NUM_OUT    = 32;
  localparam int NUM_IN     = 32;
  localparam int IDX_W      = 5;
  localparam int GROUP_W    = 6;
  localparam int WORD_BITS  = 193;
  // Clamp bit enters first, so it ends at the top of the word
  localparam int CLAMP_POS  = 192;
  // Offset of the output enable bit inside a group
  localparam int EN_OFS     = 5;
  localparam int SYNC_DEPTH = 2;
  localparam logic [WORD_BITS-1:0] WORD_RESET = '0;
endpackage

//--- config_rank_if.sv
/*
  Carrier between the serial front end and the committed latch rank.
  Assumes both ends share ref_clk and rstn.
*/
`timescale 1ns/100ps
`default_nettype none
interface config_rank_if;
  logic [crosspoint_pkg::WORD_BITS-1:0]           word;
  logic                                           commit;
  logic [crosspoint_pkg::NUM_OUT-1:0]             enable;
  logic [crosspoint_pkg::NUM_OUT-1:0][crosspoint_pkg::IDX_W-1:0] srcIdx;
  logic                                           clamp;

  modport ctrl (output word, output commit, input enable, input srcIdx, input clamp);
  modport store (input word, input commit, output enable, output srcIdx, output clamp);
endinterface
`default_nettype wire

//--- config_rank.sv
/*
  Second latch rank: per-output enable and source index plus the global
  clamp enable, loaded from the shift word in one edge on commit.
  Assumes commit is already qualified by select and reset.
*/
`timescale 1ns/100ps
`default_nettype none
module config_rank (
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  config_rank_if.store      bus
);
  logic [crosspoint_pkg::NUM_OUT-1:0]                            enable_reg;
  logic [crosspoint_pkg::NUM_OUT-1:0][crosspoint_pkg::IDX_W-1:0] srcIdx_reg;
  logic                                                          clamp_reg;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      enable_reg <= '0;
      srcIdx_reg <= '0;
      clamp_reg  <= 1'b0;
    end else if (bus.commit) begin
      clamp_reg <= bus.word[crosspoint_pkg::CLAMP_POS];
      for (int n = 0; n < crosspoint_pkg::NUM_OUT; n++) begin
        // All groups in one edge
        enable_reg[n] <= bus.word[n*crosspoint_pkg::GROUP_W + crosspoint_pkg::EN_OFS];
        srcIdx_reg[n] <= bus.word[n*crosspoint_pkg::GROUP_W +: crosspoint_pkg::IDX_W];
      end
    end
  end

  assign bus.enable = enable_reg;
  assign bus.srcIdx = srcIdx_reg;
  assign bus.clamp  = clamp_reg;

  commit_all_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    bus.commit |=> enable_reg[31] == $past(bus.word[191]) &&
      enable_reg[0] == $past(bus.word[5]) && srcIdx_reg[0] == $past(bus.word[4:0]))
    else $error("commit did not load all outputs together");

  rank_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !bus.commit |=> $stable(enable_reg) && $stable(srcIdx_reg) && $stable(clamp_reg))
    else $error("latch rank changed without commit");
endmodule
`default_nettype wire

//--- crosspoint_serial_config.sv
/*
  Serial configuration logic of a 32x32 crosspoint switch with overlay
  multiplexers, modelled with one-bit digital lanes for the video paths.
  Assumes all pin inputs are asynchronous to ref_clk; serial clock is much
  slower than ref_clk (at least four ref_clk periods per phase).
*/
// Contract
// - Reset low disables outputs and clears shift register and latch rank.
// - Selected and not committing: shift serial input on each serial clock rising edge.
// - Serial output shows the bit that entered 192 serial clock rises earlier.
// - Selected with commit low: copy shift register into the latch rank.
// - Commit updates all 32 outputs at the same moment.
// - Deselected: ignore clock, data and commit; state stays unchanged.
// - Each output can take any of the 32 normal inputs by its index.
// - Each output selects exactly one input or none.
// - One input may feed several outputs at once.
// - Each output has a 2:1 mux between selected input and overlay input.
// - First serial bit sets all input clamps together.
// - Disabled or reset outputs are high impedance.
// - Word order: clamp, then outputs 31 down to 0, enable then index MSB first.
// - Output enable bit 0 disables output and ignores its source index.
// - Clamp bit 0 turns clamps off, 1 turns them on.
// - Overlay select high passes overlay input, low passes normal input.
`timescale 1ns/100ps
`default_nettype none
module crosspoint_serial_config #(
  parameter int NumOut = crosspoint_pkg::NUM_OUT,
  parameter int NumIn  = crosspoint_pkg::NUM_IN
) (
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire logic              serClk,
  input  wire logic              serDataIn,
  input  wire logic              selectN,
  input  wire logic              commitN,
  input  wire logic [NumIn-1:0]  normal_input,
  input  wire logic [NumOut-1:0] overlay_input,
  input  wire logic [NumOut-1:0] overlay_select_pin,
  output logic                   serDataOut,
  output logic [NumOut-1:0]      outData,
  output logic [NumOut-1:0]      outOe,
  output logic                   clampOn
);
  localparam int WB = crosspoint_pkg::WORD_BITS;
  localparam int SW = 4 + NumIn + 2 * NumOut;
  // Pins read as deselected and not committing, so no false commit after reset
  localparam logic [SW-1:0] SyncIdle = SW'(4'hC);

  // One-hot input stage choice for one output; none when disabled
  function automatic logic [NumIn-1:0] decodeSrc(
    input logic                             en,
    input logic [crosspoint_pkg::IDX_W-1:0] idx
  );
    logic [NumIn-1:0] hot;
    hot = '0;
    if (en) begin
      hot[idx] = 1'b1;
    end
    return hot;
  endfunction

  config_rank_if rankBus ();

  logic [SW-1:0]          pinMeta_reg;
  logic [SW-1:0]          pinSync_reg;
  logic                   clkPrev_reg;
  logic [WB-1:0]          shift_reg;
  logic [WB-1:0]          shift_next;
  logic                   serDataOut_reg;
  logic [NumOut-1:0]      outData_reg;
  logic [NumOut-1:0]      outData_next;
  logic [NumOut-1:0]      outOe_reg;

  wire logic              clkS   = pinSync_reg[0];
  wire logic              dataS  = pinSync_reg[1];
  wire logic              selS   = pinSync_reg[2];
  wire logic              comS   = pinSync_reg[3];
  wire logic [NumIn-1:0]  inS    = pinSync_reg[4 +: NumIn];
  wire logic [NumOut-1:0] ovlS   = pinSync_reg[4 + NumIn +: NumOut];
  wire logic [NumOut-1:0] ovlSelS = pinSync_reg[4 + NumIn + NumOut +: NumOut];

  wire logic clkRise  = clkS && !clkPrev_reg;
  wire logic shiftNow = !selS && comS && clkRise;
  wire logic commitNow = !selS && !comS;

  // Two-stage synchronisers for every pin
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pinMeta_reg <= SyncIdle;
      pinSync_reg <= SyncIdle;
      clkPrev_reg <= 1'b0;
    end else begin
      pinMeta_reg <= {overlay_select_pin, overlay_input, normal_input,
                      commitN, selectN, serDataIn, serClk};
      pinSync_reg <= pinMeta_reg;
      clkPrev_reg <= clkS;
    end
  end

  assign shift_next = shiftNow ? {shift_reg[WB-2:0], dataS} : shift_reg;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      shift_reg      <= crosspoint_pkg::WORD_RESET;
      serDataOut_reg <= 1'b0;
    end else begin
      shift_reg      <= shift_next;
      serDataOut_reg <= shift_reg[WB-1];
    end
  end

  assign rankBus.word   = shift_reg;
  assign rankBus.commit = commitNow;

  config_rank rank (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .bus     (rankBus)
  );

  // Per-output selector and overlay mux; outputs are independent
  genvar g;
  generate
    for (g = 0; g < NumOut; g++) begin : lane
      wire logic [NumIn-1:0] hot = decodeSrc(rankBus.enable[g], rankBus.srcIdx[g]);
      wire logic picked = |(hot & inS);
      assign outData_next[g] = ovlSelS[g] ? ovlS[g] : picked;
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      outData_reg <= '0;
      outOe_reg   <= '0;
    end else begin
      outData_reg <= outData_next;
      outOe_reg   <= rankBus.enable;
    end
  end

  assign serDataOut = serDataOut_reg;
  assign outData    = outData_reg;
  assign outOe      = outOe_reg;
  assign clampOn    = rankBus.clamp;

  reset_clear_a: assert property (@(posedge ref_clk)
    $rose(rstn) |-> outOe == '0 && shift_reg == '0 && rankBus.enable == '0)
    else $error("reset left state set");

  shift_in_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    shiftNow |=> shift_reg[0] == $past(dataS) && shift_reg[WB-1:1] == $past(shift_reg[WB-2:0]))
    else $error("serial bit not shifted in");

  chain_out_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    shiftNow ##1 !shiftNow |-> ##1 serDataOut == $past(shift_reg[WB-2], 2))
    else $error("serial output not the oldest bit");

  commit_copy_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    commitNow |=> clampOn == $past(shift_reg[WB-1]) ##1 outOe == $past(rankBus.enable))
    else $error("commit did not reach outputs");

  deselect_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    selS |=> $stable(shift_reg) && $stable(rankBus.enable) && $stable(clampOn))
    else $error("state changed while deselected");

  one_source_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    $onehot0(lane[0].hot) && $onehot0(lane[31].hot) && (lane[5].hot == '0 || rankBus.enable[5]))
    else $error("more than one input stage selected");

  disabled_hiz_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (outOe & ~$past(rankBus.enable)) == '0)
    else $error("disabled output still driven");

  overlay_pass_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    ovlSelS[0] |=> outData[0] == $past(ovlS[0]))
    else $error("overlay input not passed");

  normal_pass_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !ovlSelS[1] && rankBus.enable[1] |=> outData[1] == $past(inS[rankBus.srcIdx[1]]))
    else $error("normal input not routed");

  shift_block_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !comS |=> $stable(shift_reg))
    else $error("shifted while commit low");

  multicast_ok_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    rankBus.enable[0] && rankBus.enable[1] && rankBus.srcIdx[0] == rankBus.srcIdx[1] &&
      !ovlSelS[0] && !ovlSelS[1] |=> outData[0] == outData[1])
    else $error("shared input not seen on both outputs");

  disabled_quiet_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !rankBus.enable[2] && !ovlSelS[2] |=> !outData[2])
    else $error("disabled output passed a normal input");

  mux_select_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    1'b1 |=> outData[7] ==
      $past(ovlSelS[7] ? ovlS[7] : (rankBus.enable[7] && inS[rankBus.srcIdx[7]])))
    else $error("output mux chose the wrong source");

  order_map_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    commitNow |=> rankBus.enable[17] ==
      $past(shift_reg[17 * crosspoint_pkg::GROUP_W + crosspoint_pkg::EN_OFS]) &&
      rankBus.srcIdx[17] ==
      $past(shift_reg[17 * crosspoint_pkg::GROUP_W +: crosspoint_pkg::IDX_W]))
    else $error("group landed on the wrong output");

  reset_wins_a: assert property (@(posedge ref_clk)
    !rstn |-> outOe == '0 && rankBus.enable == '0 && !clampOn && shift_reg == '0)
    else $error("state not held clear during reset");

  shift_rise_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !clkRise |=> $stable(shift_reg))
    else $error("shifted without a serial clock rise");

  clamp_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !commitNow |=> $stable(clampOn))
    else $error("clamp changed without commit");

  clamp_off_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    commitNow && !shift_reg[crosspoint_pkg::CLAMP_POS] |=> !clampOn)
    else $error("clamp left on by a zero bit");

  chain_follow_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    1'b1 |=> serDataOut == $past(shift_reg[WB-1]))
    else $error("serial output lags the word");

  deselect_outs_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    selS && $past(selS) |=> $stable(outOe))
    else $error("outputs changed while deselected");
endmodule
`default_nettype wire

//--- host_link.sv
/*
  Host side of the serial programming port.
  Assumes the device samples these pins with its own faster clock.
*/
`timescale 1ns/100ps
`default_nettype none
module host_link (
  output var logic serClk,
  output var logic serDataIn,
  output var logic selectN,
  output var logic commitN
);
  initial begin
    serClk = 1'b0;
    serDataIn = 1'b0;
    selectN = 1'b1;
    commitN = 1'b1;
  end
  task automatic open_frame(input logic sel);
    selectN = ~sel;
    #200;
  endtask
  // Data set while clock low, held past the rise
  task automatic shift_bit(input logic b);
    serDataIn = b;
    #200 serClk = 1'b1;
    #200 serClk = 1'b0;
  endtask
  // Released line shows the inverse of its last value
  task automatic close_frame();
    serDataIn = ~serDataIn;
    #150 selectN = 1'b1;
  endtask
  // Commit only after a whole word
  task automatic commit(input logic sel);
    selectN = ~sel;
    #150 commitN = 1'b0;
    #300 commitN = 1'b1;
    #150 selectN = 1'b1;
  endtask
endmodule
`default_nettype wire

//--- tb.sv
/*
  Bench of the crosspoint configuration logic.
  Assumes host_link drives the serial port pins.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct packed {
    logic [31:0] oe;
    logic [31:0] dat;
    logic        clamp;
    logic        so;
  } obs_t;
  logic         ref_clk = 1'b0;
  logic         rstn;
  logic [31:0]  normIn, ovlIn, ovlSel, rnd;
  logic [192:0] committed, shadow, w;
  wire logic    serClk, serDataIn, selectN, commitN, serDataOut, clampOn;
  wire logic [31:0] outData, outOe;
  obs_t         expQ[$];
  obs_t         head;
  int           errCount = 0;
  int           cmpCount = 0;
  event         probe;

  always #25 ref_clk = ~ref_clk;

  host_link host_link_inst (.serClk(serClk), .serDataIn(serDataIn),
    .selectN(selectN), .commitN(commitN));
  crosspoint_serial_config crosspoint_serial_config_inst (.ref_clk(ref_clk),
    .rstn(rstn), .serClk(serClk), .serDataIn(serDataIn), .selectN(selectN),
    .commitN(commitN), .normal_input(normIn), .overlay_input(ovlIn),
    .overlay_select_pin(ovlSel), .serDataOut(serDataOut), .outData(outData),
    .outOe(outOe), .clampOn(clampOn));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic obs_t model();
    obs_t e;
    for (int n = 0; n < 32; n++) begin
      e.oe[n] = committed[6*n+5];
      e.dat[n] = ovlSel[n] ? ovlIn[n] : e.oe[n] & normIn[committed[6*n+:5]];
    end
    if (!rstn) e.dat = '0;
    e.clamp = committed[192];
    e.so = shadow[192];
    return e;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      errCount++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic expect_now(input int n);
    expQ.push_back(model());
    repeat (n) @(negedge ref_clk);
    -> probe;
  endtask
  task automatic new_pins();
    @(negedge ref_clk);
    rnd = lfsr(rnd);
    normIn = rnd;
    ovlIn = ~rnd ^ {rnd[15:0], rnd[31:16]};
    rnd = lfsr(rnd);
    ovlSel = rnd;
  endtask
  task automatic make_word(input logic clamp);
    repeat (7) begin
      rnd = lfsr(rnd);
      w = {w[160:0], rnd};
    end
    w[192] = clamp;
    w[5] = 1'b1;
    w[11] = 1'b1;
    w[10:6] = w[4:0];
  endtask
  task automatic send_word(input logic sel);
    host_link_inst.open_frame(sel);
    for (int i = 192; i >= 0; i--) begin
      host_link_inst.shift_bit(w[i]);
      if (sel) shadow = {shadow[191:0], w[i]};
      expect_now(2);
    end
    host_link_inst.close_frame();
  endtask
  task automatic tally_and_finish();
    if (errCount == 0 && cmpCount > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Compares the oldest note with what the outputs show
  initial forever begin
    @(probe);
    head = expQ.pop_front();
    check(outOe, head.oe);
    check(outData, head.dat);
    check({31'h0, clampOn}, {31'h0, head.clamp});
    check({31'h0, serDataOut}, {31'h0, head.so});
  end

  initial begin
    #3000000;
    errCount++;
    tally_and_finish();
  end

  initial begin
    rstn = 1'b0;
    normIn = '0;
    ovlIn = '0;
    ovlSel = '0;
    rnd = 32'h8;
    committed = '0;
    shadow = '0;
    w = '0;
    repeat (14) @(negedge ref_clk);
    expect_now(2);
    rstn = 1'b1;
    for (int k = 0; k < 3; k++) begin
      make_word(k[0]);
      new_pins();
      send_word(1'b1);
      expect_now(4);
      host_link_inst.commit(1'b1);
      committed = w;
      expect_now(4);
      repeat (6) begin
        new_pins();
        expect_now(4);
      end
    end
    w = ~w;
    send_word(1'b0);
    expect_now(4);
    host_link_inst.commit(1'b0);
    expect_now(4);
    @(negedge ref_clk);
    rstn = 1'b0;
    committed = '0;
    shadow = '0;
    host_link_inst.commit(1'b1);
    expect_now(4);
    rstn = 1'b1;
    expect_now(4);
    tally_and_finish();
  end
endmodule
`default_nettype wire
